// ==== verilog/pbcao_pkg.sv ====
`default_nettype none
// Constants for the Port B / Port C alternate-function override block
package pbcao_pkg;
  // Width of each port
  localparam int PBCAO_PORT_W = 8;
  // Value of every pin control output after reset, except the Port C bit 7 output and enable
  localparam logic [7:0] PBCAO_RST_BYTE = 8'h00;
  // Port B bit positions of the serial interface pins
  localparam int PBCAO_SS_BIT = 0;
  localparam int PBCAO_SCK_BIT = 1;
  localparam int PBCAO_MOSI_BIT = 2;
  localparam int PBCAO_MISO_BIT = 3;
  // Port B bit positions of the timer compare pins
  localparam int PBCAO_TMR2A_BIT = 4;
  localparam int PBCAO_TMR1A_BIT = 5;
  localparam int PBCAO_TMR1B_BIT = 6;
  localparam int PBCAO_OC7_BIT = 7;
  // Port C pin carrying the divided clock
  localparam int PBCAO_DIVCLK_BIT = 7;
  // Address bit carried by Port C bit 0
  localparam int PBCAO_ADDR_BASE = 8;
  // Mask value below which each Port C pin is an address pin
  localparam logic [3:0] PBCAO_MASK_LIMIT [0:7] = '{
    4'h7, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1
  };
  // Pin synchroniser depth
  localparam int PBCAO_SYNC_STAGES = 2;
endpackage : pbcao_pkg
`default_nettype wire

// ==== verilog/pbcao_override.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbcao_override (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Port B register bits
  input wire logic [7:0] portb_out_reg,
  input wire logic [7:0] portb_dir_reg,
  input wire logic global_pullup_disable,
  // Serial interface control and outputs
  input wire logic spi_enable_bit,
  input wire logic spi_master_select,
  input wire logic spi_slave_out_data,
  input wire logic spi_master_out_data,
  input wire logic spi_sck_out,
  // Timer compare outputs and their enables
  input wire logic timer0_compare_a_out,
  input wire logic timer0_compare_a_en,
  input wire logic timer1_compare_c_out,
  input wire logic timer1_compare_c_en,
  input wire logic timer1_compare_b_out,
  input wire logic timer1_compare_b_en,
  input wire logic timer1_compare_a_out,
  input wire logic timer1_compare_a_en,
  input wire logic timer2_compare_a_out,
  input wire logic timer2_compare_a_en,
  // Port C register bits and external memory
  input wire logic [7:0] portc_out_reg,
  input wire logic [7:0] portc_dir_reg,
  input wire logic ext_memory_enable,
  input wire logic [2:0] high_address_mask,
  input wire logic [7:0] ext_addr_high,
  // Clock output
  input wire logic clock_out_fuse,
  input wire logic divided_clock_output,
  // Port B pins
  input wire logic [7:0] portb_pin_in,
  output logic [7:0] portb_pin_out_ff,
  output logic [7:0] portb_pin_oe_ff,
  output logic [7:0] portb_pullup_ff,
  // Port C pins
  output logic [7:0] portc_pin_out_ff,
  output logic [7:0] portc_pin_oe_ff,
  output logic [7:0] portc_pullup_ff,
  // Serial interface inputs taken from the pins
  output logic spi_master_in_ff,
  output logic spi_slave_in_ff,
  output logic spi_sck_in_ff,
  output logic spi_ss_active_ff
);

  // Override merge: enabled bits take the override value
  function automatic logic [7:0] pbcao_mix(
    input logic [7:0] oe,
    input logic [7:0] ov,
    input logic [7:0] norm
  );
    return (oe & ov) | (~oe & norm);
  endfunction : pbcao_mix

  logic spi_m;
  logic spi_s;
  logic oc7_en;
  logic oc7_val;
  logic [7:0] pb_pull_en;
  logic [7:0] pb_pull_val;
  logic [7:0] pb_dir_en;
  logic [7:0] pb_val_en;
  logic [7:0] pb_val;
  logic [7:0] pc_sel;
  logic [7:0] pc_drive_en;
  logic [7:0] pc_val;
  logic [7:0] nxt_portb_out;
  logic [7:0] nxt_portb_oe;
  logic [7:0] nxt_portb_pull;
  logic [7:0] nxt_portc_out;
  logic [7:0] nxt_portc_oe;
  logic [7:0] nxt_portc_pull;
  logic [7:0] pin_meta_ff;
  logic [7:0] pin_sync_ff;

  // Serial role decode
  assign spi_m = spi_enable_bit & spi_master_select;
  assign spi_s = spi_enable_bit & ~spi_master_select;

  // Bit 7 merges two compare outputs; port bit picks OR or AND
  assign oc7_en = timer0_compare_a_en | timer1_compare_c_en;
  always_comb begin
    if (timer0_compare_a_en && timer1_compare_c_en) begin
      oc7_val = portb_out_reg[7] ? (timer0_compare_a_out | timer1_compare_c_out)
                                 : (timer0_compare_a_out & timer1_compare_c_out);
    end else if (timer0_compare_a_en) begin
      oc7_val = timer0_compare_a_out;
    end else begin
      oc7_val = timer1_compare_c_out;
    end
  end

  // Port B override vectors
  always_comb begin
    pb_pull_en = {4'h0, spi_m, spi_s, spi_s, spi_s};
    pb_pull_val = {4'h0, portb_out_reg[3:0] & ~{4{global_pullup_disable}}};
    pb_dir_en = pb_pull_en;
    pb_val_en = {oc7_en, timer1_compare_b_en, timer1_compare_a_en,
                 timer2_compare_a_en, spi_s, spi_m, spi_m, 1'b0};
    pb_val = {oc7_val, timer1_compare_b_out, timer1_compare_a_out,
              timer2_compare_a_out, spi_slave_out_data,
              spi_master_out_data, spi_sck_out, 1'b0};
  end

  // Port C address pin selection from the mask
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pc_sel[i] = ext_memory_enable &&
                  ({1'b0, high_address_mask} < pbcao_pkg::PBCAO_MASK_LIMIT[i]);
    end
  end

  // Port C override vectors
  always_comb begin
    pc_drive_en = pc_sel;
    pc_drive_en[pbcao_pkg::PBCAO_DIVCLK_BIT] = clock_out_fuse |
                                         pc_sel[pbcao_pkg::PBCAO_DIVCLK_BIT];
    pc_val = ext_addr_high;
    pc_val[pbcao_pkg::PBCAO_DIVCLK_BIT] = clock_out_fuse ? divided_clock_output
                                         : ext_addr_high[7];
  end

  // Resolved pin controls
  always_comb begin
    nxt_portb_oe = pbcao_mix(pb_dir_en, 8'h00, portb_dir_reg);
    nxt_portb_out = pbcao_mix(pb_val_en, pb_val, portb_out_reg);
    nxt_portb_pull = pbcao_mix(pb_pull_en, pb_pull_val,
      portb_out_reg & ~portb_dir_reg & ~{8{global_pullup_disable}});
    nxt_portc_oe = pbcao_mix(pc_drive_en, 8'hff, portc_dir_reg);
    nxt_portc_out = pbcao_mix(pc_drive_en, pc_val, portc_out_reg);
    nxt_portc_pull = pbcao_mix(pc_sel, 8'h00,
      portc_out_reg & ~portc_dir_reg & ~{8{global_pullup_disable}});
  end

  // Port B pin drivers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      portb_pin_out_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      portb_pin_oe_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      portb_pullup_ff <= pbcao_pkg::PBCAO_RST_BYTE;
    end else begin
      portb_pin_out_ff <= nxt_portb_out;
      portb_pin_oe_ff <= nxt_portb_oe;
      portb_pullup_ff <= nxt_portb_pull;
    end
  end

  // Port C pin drivers; clock pin keeps running through reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      portc_pin_out_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      portc_pin_oe_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      portc_pullup_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      portc_pin_out_ff[pbcao_pkg::PBCAO_DIVCLK_BIT] <=
        clock_out_fuse & divided_clock_output;
      portc_pin_oe_ff[pbcao_pkg::PBCAO_DIVCLK_BIT] <= clock_out_fuse;
    end else begin
      portc_pin_out_ff <= nxt_portc_out;
      portc_pin_oe_ff <= nxt_portc_oe;
      portc_pullup_ff <= nxt_portc_pull;
    end
  end

  // Two-stage synchroniser on the Port B pins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pin_meta_ff <= pbcao_pkg::PBCAO_RST_BYTE;
      pin_sync_ff <= pbcao_pkg::PBCAO_RST_BYTE;
    end else begin
      pin_meta_ff <= portb_pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Serial inputs routed from the synchronised pins
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spi_master_in_ff <= 1'b0;
      spi_slave_in_ff <= 1'b0;
      spi_sck_in_ff <= 1'b0;
      spi_ss_active_ff <= 1'b0;
    end else begin
      spi_master_in_ff <= pin_sync_ff[pbcao_pkg::PBCAO_MISO_BIT];
      spi_slave_in_ff <= pin_sync_ff[pbcao_pkg::PBCAO_MOSI_BIT];
      spi_sck_in_ff <= pin_sync_ff[pbcao_pkg::PBCAO_SCK_BIT];
      spi_ss_active_ff <= spi_s & ~pin_sync_ff[pbcao_pkg::PBCAO_SS_BIT];
    end
  end

  // Checks on the pin controls and the serial inputs
  chk_miso_master_in: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_m |=> !portb_pin_oe_ff[3])
    else $error("MISO not forced to input in master mode");

  chk_miso_slave_dir: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_s |=> portb_pin_oe_ff[3] == $past(portb_dir_reg[3]) &&
              portb_pin_out_ff[3] == $past(spi_slave_out_data))
    else $error("MISO slave direction or data wrong");

  chk_mosi_slave_in: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_s |=> !portb_pin_oe_ff[2])
    else $error("MOSI not forced to input in slave mode");

  chk_sck_role_dir: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_enable_bit |=> portb_pin_oe_ff[1] ==
      ($past(spi_master_select) & $past(portb_dir_reg[1])))
    else $error("SCK direction wrong for role");

  chk_ss_no_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> portb_pin_out_ff[0] == $past(portb_out_reg[0]) &&
             (!$past(spi_s) || !portb_pin_oe_ff[0]))
    else $error("SS value overridden or not input in slave mode");

  chk_ss_select: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_s && !portb_pin_in[0] ##1 spi_s && !portb_pin_in[0]
      ##1 spi_s |=> spi_ss_active_ff)
    else $error("Low SS did not select the slave");

  chk_forced_pullup: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_s |=> portb_pullup_ff[2:0] ==
      ($past(portb_out_reg[2:0]) & ~{3{$past(global_pullup_disable)}}))
    else $error("Forced input pull-up wrong");

  chk_mosi_master_out: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    spi_m |=> portb_pin_out_ff[2:1] ==
      {$past(spi_master_out_data), $past(spi_sck_out)})
    else $error("Master output or clock not driven");

  chk_miso_route_in: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    1'b1 ##3 1'b1 |-> spi_master_in_ff == $past(portb_pin_in[3], 3))
    else $error("MISO input not routed in three cycles");

  chk_timer_value: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    timer1_compare_b_en |=> portb_pin_out_ff[6] == $past(timer1_compare_b_out) &&
      portb_pin_oe_ff[7:4] == $past(portb_dir_reg[7:4]))
    else $error("Timer compare value or direction wrong");

  chk_addr_pin: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ext_memory_enable && high_address_mask == 3'h0 && !clock_out_fuse
      |=> portc_pin_oe_ff == 8'hff && portc_pullup_ff == 8'h00 &&
          portc_pin_out_ff == $past(ext_addr_high))
    else $error("Address byte not driven on Port C");

  chk_divclk_fuse: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    clock_out_fuse |=> portc_pin_oe_ff[7] &&
      portc_pin_out_ff[7] == $past(divided_clock_output))
    else $error("Divided clock missing on Port C bit 7");

  chk_divclk_reset: assert property (
    @(posedge sys_clk)
    clock_out_fuse && !rst_n |=> portc_pin_oe_ff[7] &&
      portc_pin_out_ff[7] == $past(divided_clock_output))
    else $error("Divided clock stopped during reset");

  chk_pc7_release: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !clock_out_fuse && high_address_mask != 3'h0
      |=> portc_pin_oe_ff[7] == $past(portc_dir_reg[7]) &&
          portc_pin_out_ff[7] == $past(portc_out_reg[7]))
    else $error("Port C bit 7 overridden without cause");

  chk_mask_limit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    ext_memory_enable && high_address_mask == 3'h6
      |=> portc_pin_oe_ff[1:0] == 2'b11 &&
          portc_pin_out_ff[2] == $past(portc_out_reg[2]))
    else $error("Mask 6 released wrong Port C pins");

  chk_normal_path: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    !spi_enable_bit && !ext_memory_enable && !clock_out_fuse
      |=> portb_pin_oe_ff == $past(portb_dir_reg) &&
          portc_pin_out_ff == $past(portc_out_reg))
    else $error("Port setting not applied without overrides");

  // Main scenarios
  cov_spi_master: cover property (@(posedge sys_clk) disable iff (!rst_n)
    spi_m ##1 spi_m);
  cov_slave_sel: cover property (@(posedge sys_clk) disable iff (!rst_n)
    spi_ss_active_ff);
  cov_addr_mode: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ext_memory_enable && high_address_mask == 3'h3);
  cov_divclk_reset: cover property (@(posedge sys_clk)
    clock_out_fuse && !rst_n ##1 rst_n);

endmodule : pbcao_override
`default_nettype wire

// ==== test/pbcao_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pbcao_pin_model (
  // Clock
  input wire logic sys_clk,
  // Levels an outside serial master puts on the pins
  input wire logic master_select,
  input wire logic miso_lvl,
  input wire logic mosi_lvl,
  input wire logic sck_lvl,
  // Port B pin levels
  output logic [7:0] pin_lvl
);
  logic churn_ff = 1'b0;

  // Changing pattern on lines nobody drives, so stale values never pass
  always_ff @(posedge sys_clk) begin
    churn_ff <= ~churn_ff;
  end

  // Select is low only while the outside master addresses the slave
  assign pin_lvl[0] = master_select ? 1'b0 : 1'b1;
  assign pin_lvl[3:1] = master_select ? {miso_lvl, mosi_lvl, sck_lvl} : {3{churn_ff}};
  assign pin_lvl[7:4] = {4{churn_ff}};
endmodule : pbcao_pin_model
`default_nettype wire

// ==== test/pbcao_override_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module pbcao_override_tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] pb_out = 8'h00, pb_dir = 8'h00, pc_out = 8'h00, pc_dir = 8'h00, addr = 8'h00;
  logic pu_off = 1'b0, spi_on = 1'b0, as_mst = 1'b0, s_out = 1'b0, m_out = 1'b0, sck_o = 1'b0;
  logic [4:0] tmr_v = 5'h00, tmr_e = 5'h00;
  logic mem_on = 1'b0, fuse = 1'b1, dclk = 1'b0;
  logic [2:0] amask = 3'h0;
  logic sel = 1'b0, p_mosi = 1'b0, p_sck = 1'b0, p_miso = 1'b0;
  wire [7:0] pins;
  logic [7:0] b_out, b_oe, b_pu, c_out, c_oe, c_pu;
  logic m_in, s_in, k_in, ss_act;
  logic [7:0] e_boe, e_bout, e_bpu, e_coe, e_cout, e_cpu;
  int err_count = 0;
  int num_checks = 0;

  // Clock, 4 ns period
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  pbcao_pin_model far_side (.sys_clk(sys_clk), .master_select(sel), .miso_lvl(p_miso),
    .mosi_lvl(p_mosi), .sck_lvl(p_sck), .pin_lvl(pins));

  pbcao_override uut (.sys_clk(sys_clk), .rst_n(rst_n), .portb_out_reg(pb_out),
    .portb_dir_reg(pb_dir), .global_pullup_disable(pu_off), .spi_enable_bit(spi_on),
    .spi_master_select(as_mst), .spi_slave_out_data(s_out), .spi_master_out_data(m_out),
    .spi_sck_out(sck_o), .timer0_compare_a_out(tmr_v[4]), .timer0_compare_a_en(tmr_e[4]),
    .timer1_compare_c_out(tmr_v[3]), .timer1_compare_c_en(tmr_e[3]),
    .timer1_compare_b_out(tmr_v[2]), .timer1_compare_b_en(tmr_e[2]),
    .timer1_compare_a_out(tmr_v[1]), .timer1_compare_a_en(tmr_e[1]),
    .timer2_compare_a_out(tmr_v[0]), .timer2_compare_a_en(tmr_e[0]),
    .portc_out_reg(pc_out), .portc_dir_reg(pc_dir), .ext_memory_enable(mem_on),
    .high_address_mask(amask), .ext_addr_high(addr), .clock_out_fuse(fuse),
    .divided_clock_output(dclk), .portb_pin_in(pins), .portb_pin_out_ff(b_out),
    .portb_pin_oe_ff(b_oe), .portb_pullup_ff(b_pu), .portc_pin_out_ff(c_out),
    .portc_pin_oe_ff(c_oe), .portc_pullup_ff(c_pu), .spi_master_in_ff(m_in),
    .spi_slave_in_ff(s_in), .spi_sck_in_ff(k_in), .spi_ss_active_ff(ss_act));

  // Expected pin controls from the present inputs
  task automatic calc;
    int lim;
    e_boe = pb_dir;
    e_bout = pb_out;
    e_bpu = pb_out & ~pb_dir & {8{~pu_off}};
    if (spi_on && as_mst) begin
      e_boe[3] = 1'b0;
      e_bpu[3] = pb_out[3] & ~pu_off;
      e_bout[2] = m_out;
      e_bout[1] = sck_o;
    end
    if (spi_on && !as_mst) begin
      e_boe[2:0] = 3'h0;
      e_bpu[2:0] = pb_out[2:0] & {3{~pu_off}};
      e_bout[3] = s_out;
    end
    for (int i = 0; i < 3; i++) if (tmr_e[i]) e_bout[4+i] = tmr_v[i];
    case (tmr_e[4:3])
      2'b11: e_bout[7] = pb_out[7] ? (tmr_v[4] | tmr_v[3]) : (tmr_v[4] & tmr_v[3]);
      2'b10: e_bout[7] = tmr_v[4];
      2'b01: e_bout[7] = tmr_v[3];
      default: e_bout[7] = pb_out[7];
    endcase
    e_coe = pc_dir;
    e_cout = pc_out;
    e_cpu = pc_out & ~pc_dir & {8{~pu_off}};
    for (int n = 0; n < 8; n++) begin
      lim = (n == 7) ? 1 : ((n >= 2) ? 8 - n : 7);
      if (mem_on && int'(amask) < lim) begin
        e_coe[n] = 1'b1;
        e_cpu[n] = 1'b0;
        e_cout[n] = addr[n];
      end
    end
    if (fuse) begin
      e_coe[7] = 1'b1;
      e_cout[7] = dclk;
    end
  endtask : calc

  // One registered step, then every pin control compared
  task automatic step;
    calc();
    @(posedge sys_clk);
    #1;
    `CHK("portb_oe", e_boe, b_oe)
    `CHK("portb_out", e_bout, b_out)
    `CHK("portb_pullup", e_bpu, b_pu)
    `CHK("portc_oe", e_coe, c_oe)
    `CHK("portc_out", e_cout, c_out)
    `CHK("portc_pullup", e_cpu, c_pu)
  endtask : step

  // Pin levels from the far side, seen three edges later
  task automatic pin_chk(input logic sv, input logic mv, input logic exp_ss);
    spi_on = 1'b1;
    as_mst = mv;
    sel = sv;
    p_miso = 1'b1;
    p_mosi = 1'b1;
    p_sck = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("ss_active", exp_ss, ss_act)
    if (sv) begin
      `CHK("master_in", 1'b1, m_in)
      `CHK("slave_in", 1'b1, s_in)
      `CHK("sck_in", 1'b0, k_in)
    end
  endtask : pin_chk

  // Verdict and end of run
  task automatic finish_test;
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk);
      #1;
      `CHK("rst_portb_oe", 8'h00, b_oe)
      `CHK("rst_clk_oe", 1'b1, c_oe[7])
      `CHK("rst_clk_out", dclk, c_out[7])
      dclk = ~dclk;
    end
    rst_n = 1'b1;
    pc_dir = 8'h00;
    step();
    fuse = 1'b0;
    for (int k = 0; k < 32; k++) begin
      {spi_on, as_mst, pu_off, s_out} = k[3:0];
      pb_dir = {8{k[0]}} ^ 8'h5a ^ {4'h0, k[4], 3'h0};
      pb_out = 8'h3c ^ {8{k[1]}};
      m_out = ~k[0];
      sck_o = k[2];
      step();
    end
    spi_on = 1'b0;
    for (int k = 0; k < 64; k++) begin
      {pb_out[7], tmr_e} = k[5:0];
      tmr_v = {k[1], k[4], k[0], ~k[2], k[3]};
      step();
    end
    pc_dir = 8'h33;
    pc_out = 8'hc6;
    for (int k = 0; k < 64; k++) begin
      {pu_off, fuse, mem_on, amask} = k[5:0];
      addr = 8'ha5 ^ k[7:0];
      dclk = k[0];
      step();
    end
    pin_chk(1'b1, 1'b0, 1'b1);
    pin_chk(1'b0, 1'b0, 1'b0);
    pin_chk(1'b1, 1'b1, 1'b0);
    finish_test();
  end
endmodule : pbcao_override_tb
`default_nettype wire
